/* File: hdl/exec_pkg.sv */
/*
 Constants and carrier types for the three-instruction execution block.
 Assumes a 12-bit instruction word and 8-bit data path.
*/
package exec_pkg;
  localparam logic [11:0] CLR_WDT_WORD   = 12'h004;
  localparam logic [11:0] OP_MASK        = 12'hfc0;
  localparam logic [11:0] COMP_OP        = 12'h240;
  localparam logic [11:0] DEC_OP         = 12'h0c0;
  localparam int          DEST_BIT       = 5;
  localparam logic [7:0]  WREG_RESET     = 8'h00;
  localparam logic [7:0]  WDT_ZERO       = 8'h00;
  localparam logic [7:0]  PRESCALE_ZERO  = 8'h00;
  localparam int          NUM_FILES      = 32;

  typedef struct packed {
    logic       we;
    logic [4:0] addr;
    logic [7:0] data;
  } file_wr_t;

  typedef struct packed {
    logic       clr_wdt;
    logic       clr_prescale;
    logic       set_status;
  } wdt_ctl_t;
endpackage : exec_pkg

/* File: hdl/file_regs.sv */
/*
 Little 32 x 8 file register memory with registered read data.
 Assumes the address is presented one cycle before the data is used.
*/
`timescale 1ns/1ns
`default_nettype none
module file_regs (
  input  wire logic             clk_sys_i,
  input  wire logic [4:0]       rd_addr_i,
  output var  logic [7:0]       rd_data_o,
  input  wire exec_pkg::file_wr_t wr_i
);
  // Zero at power-up; an unknown word would poison every later result
  logic [7:0] mem_r [exec_pkg::NUM_FILES] = '{default: 8'h00};

  always_ff @(posedge clk_sys_i) begin
    if (wr_i.we) begin
      mem_r[wr_i.addr] <= wr_i.data;
    end
  end

  // Write-first so a back-to-back read sees fresh data
  always_ff @(posedge clk_sys_i) begin
    if (wr_i.we && wr_i.addr == rd_addr_i) begin
      rd_data_o <= wr_i.data;
    end else begin
      rd_data_o <= mem_r[rd_addr_i];
    end
  end
endmodule : file_regs
`default_nettype wire

/* File: hdl/wdt_clear_comp_dec_exec.sv */
/*
 Executes clear-watchdog, complement-file and decrement-file instructions.
 Assumes the instruction word is stable for the whole execute cycle and that
 the file operand address appears on the fetch bus one cycle ahead.
*/
`timescale 1ns/1ns
`default_nettype none
module wdt_clear_comp_dec_exec (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  input  wire logic [11:0] fetch_word_i,
  input  wire logic        fetch_valid_i,
  input  wire logic        prescale_to_wdt_i,
  output var  logic [7:0]  watchdog_counter_o,
  output var  logic [7:0]  prescaler_o,
  output var  logic        timeout_status_bit_o,
  output var  logic        powerdown_status_bit_o,
  output var  logic        zero_flag_o,
  output var  logic [7:0]  wreg_o,
  output var  logic        file_we_o,
  output var  logic [4:0]  file_addr_o,
  output var  logic [7:0]  file_data_o
);
  logic [1:0]  rst_sync_r;
  logic        rst_n;
  logic [11:0] instr_r;
  logic        valid_r;
  logic [7:0]  operand;
  logic        is_clr;
  logic        is_comp;
  logic        is_dec;
  logic        to_file;
  logic [7:0]  result;
  exec_pkg::file_wr_t wr;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // Latch the word so the registered file read lines up with execute
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      instr_r <= 12'h000;
      valid_r <= 1'b0;
    end else begin
      instr_r <= fetch_word_i;
      valid_r <= fetch_valid_i;
    end
  end

  file_regs u_file_regs (
    .clk_sys_i (clk_sys_i),
    .rd_addr_i (fetch_word_i[4:0]),
    .rd_data_o (operand),
    .wr_i      (wr)
  );

  assign is_clr  = valid_r && instr_r == exec_pkg::CLR_WDT_WORD;
  assign is_comp = valid_r && (instr_r & exec_pkg::OP_MASK) == exec_pkg::COMP_OP;
  assign is_dec  = valid_r && (instr_r & exec_pkg::OP_MASK) == exec_pkg::DEC_OP;
  assign to_file = instr_r[exec_pkg::DEST_BIT];
  assign result  = is_comp ? ~operand : operand - 8'h01;

  always_comb begin
    wr.we   = (is_comp || is_dec) && to_file;
    wr.addr = instr_r[4:0];
    wr.data = result;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      watchdog_counter_o <= exec_pkg::WDT_ZERO;
    end else if (is_clr) begin
      watchdog_counter_o <= exec_pkg::WDT_ZERO;
    end else begin
      // Stand-in for the watchdog's own tick, so a clear is visible
      watchdog_counter_o <= watchdog_counter_o + 8'h01;
    end
  end

  // Shared prescaler belongs to the timer otherwise; leave it alone then
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      prescaler_o <= exec_pkg::PRESCALE_ZERO;
    end else if (is_clr && prescale_to_wdt_i) begin
      prescaler_o <= exec_pkg::PRESCALE_ZERO;
    end else begin
      prescaler_o <= prescaler_o + 8'h01;
    end
  end

  // Nothing here clears them; sleep and timeout events live outside
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      timeout_status_bit_o   <= 1'b1;
      powerdown_status_bit_o <= 1'b1;
    end else if (is_clr) begin
      timeout_status_bit_o   <= 1'b1;
      powerdown_status_bit_o <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      wreg_o      <= exec_pkg::WREG_RESET;
      zero_flag_o <= 1'b0;
    end else if (is_comp || is_dec) begin
      zero_flag_o <= result == 8'h00;
      if (!to_file) begin
        wreg_o <= result;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      file_we_o   <= 1'b0;
      file_addr_o <= 5'h00;
      file_data_o <= 8'h00;
    end else begin
      file_we_o   <= wr.we;
      file_addr_o <= wr.addr;
      file_data_o <= wr.data;
    end
  end

  property p_clr_zero;
    @(posedge clk_sys_i) disable iff (!rst_n)
    is_clr |=> watchdog_counter_o == 8'h00;
  endproperty
  a_clr_zero: assert property (p_clr_zero) else $error("watchdog not zeroed");

  property p_pre_clr;
    @(posedge clk_sys_i) disable iff (!rst_n)
    is_clr && prescale_to_wdt_i |=> prescaler_o == 8'h00;
  endproperty
  a_pre_clr: assert property (p_pre_clr) else $error("prescaler not cleared");

  property p_pre_keep;
    @(posedge clk_sys_i) disable iff (!rst_n)
    is_clr && !prescale_to_wdt_i |=> prescaler_o == $past(prescaler_o) + 8'h01;
  endproperty
  a_pre_keep: assert property (p_pre_keep) else $error("timer prescaler disturbed");

  property p_status;
    @(posedge clk_sys_i) disable iff (!rst_n)
    is_clr |=> timeout_status_bit_o && powerdown_status_bit_o && $stable(zero_flag_o);
  endproperty
  a_status: assert property (p_status) else $error("status bits wrong");

  property p_comp_file;
    @(posedge clk_sys_i) disable iff (!rst_n)
    is_comp && to_file |=> file_we_o && file_data_o == ~$past(operand);
  endproperty
  a_comp_file: assert property (p_comp_file) else $error("complement write wrong");

  property p_comp_w;
    @(posedge clk_sys_i) disable iff (!rst_n)
    is_comp && !to_file |=> !file_we_o && wreg_o == ~$past(operand);
  endproperty
  a_comp_w: assert property (p_comp_w) else $error("complement to W wrong");

  property p_dec;
    @(posedge clk_sys_i) disable iff (!rst_n)
    is_dec |=> file_data_o == $past(operand) - 8'h01;
  endproperty
  a_dec: assert property (p_dec) else $error("decrement wrong");

  property p_zero;
    @(posedge clk_sys_i) disable iff (!rst_n)
    (is_comp || is_dec) |=> zero_flag_o == (file_data_o == 8'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");

  // Back-to-back use of one file register leans on the write-first read
  sequence s_file_written;
    (is_comp || is_dec) && to_file;
  endsequence

  sequence s_comp_same_file;
    is_comp && wr.addr == $past(wr.addr);
  endsequence

  sequence s_dec_same_file;
    is_dec && wr.addr == $past(wr.addr);
  endsequence

  property p_fwd_comp;
    @(posedge clk_sys_i) disable iff (!rst_n)
    s_file_written ##1 s_comp_same_file |=> file_data_o == ~$past(file_data_o);
  endproperty
  a_fwd_comp: assert property (p_fwd_comp) else $error("forwarded complement wrong");

  property p_fwd_dec;
    @(posedge clk_sys_i) disable iff (!rst_n)
    s_file_written ##1 s_dec_same_file |=> file_data_o == $past(file_data_o) - 8'h01;
  endproperty
  a_fwd_dec: assert property (p_fwd_dec) else $error("forwarded decrement wrong");

  property p_wdt_run;
    @(posedge clk_sys_i) disable iff (!rst_n)
    rst_n && !is_clr |=> watchdog_counter_o == $past(watchdog_counter_o) + 8'h01;
  endproperty
  a_wdt_run: assert property (p_wdt_run) else $error("watchdog count disturbed");

  property p_idle_file;
    @(posedge clk_sys_i) disable iff (!rst_n)
    !(is_comp || is_dec) |=> !file_we_o;
  endproperty
  a_idle_file: assert property (p_idle_file) else $error("stray file write");

  property p_dec_w;
    @(posedge clk_sys_i) disable iff (!rst_n)
    is_dec && !to_file |=> !file_we_o && wreg_o == $past(operand) - 8'h01;
  endproperty
  a_dec_w: assert property (p_dec_w) else $error("decrement to W wrong");

  property p_wreg_keep;
    @(posedge clk_sys_i) disable iff (!rst_n)
    !((is_comp || is_dec) && !to_file) |=> $stable(wreg_o);
  endproperty
  a_wreg_keep: assert property (p_wreg_keep) else $error("working register disturbed");

  property p_zero_keep;
    @(posedge clk_sys_i) disable iff (!rst_n)
    !(is_comp || is_dec) |=> $stable(zero_flag_o);
  endproperty
  a_zero_keep: assert property (p_zero_keep) else $error("zero flag disturbed");
endmodule : wdt_clear_comp_dec_exec
`default_nettype wire

/* File: sim/wdt_clear_comp_dec_exec_tb_top.sv */
/*
 Self-checking bench for the clear-watchdog, complement and decrement block.
 Assumes the internal file registers power up at zero.
*/
`timescale 1ns/1ns
`default_nettype none
module wdt_clear_comp_dec_exec_tb_top;
  logic        clk_sys_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [11:0] fetch_word_i = 12'h000;
  logic        fetch_valid_i = 1'b0;
  logic        prescale_to_wdt_i = 1'b0;
  logic [7:0]  watchdog_counter_o, prescaler_o, wreg_o, file_data_o, a, p, wd;
  logic        timeout_status_bit_o, powerdown_status_bit_o, zero_flag_o, file_we_o, z;
  logic [4:0]  file_addr_o;
  int          bad_count = 0;
  int          num_checks = 0;

  wdt_clear_comp_dec_exec dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .fetch_word_i(fetch_word_i), .fetch_valid_i(fetch_valid_i),
    .prescale_to_wdt_i(prescale_to_wdt_i), .watchdog_counter_o(watchdog_counter_o),
    .prescaler_o(prescaler_o), .timeout_status_bit_o(timeout_status_bit_o),
    .powerdown_status_bit_o(powerdown_status_bit_o), .zero_flag_o(zero_flag_o),
    .wreg_o(wreg_o), .file_we_o(file_we_o), .file_addr_o(file_addr_o),
    .file_data_o(file_data_o));

  initial begin
    forever #4 clk_sys_i = ~clk_sys_i;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic close_out;
    if (bad_count == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out

  // Word driven at edge N, latched at N+1, results looked at just after N+2
  task automatic exec(input logic [11:0] w, input logic v);
    @(posedge clk_sys_i);
    fetch_word_i  <= w;
    fetch_valid_i <= v;
    @(posedge clk_sys_i);
    fetch_valid_i <= 1'b0;
    #1;
    p  = prescaler_o;
    wd = watchdog_counter_o;
    z  = zero_flag_o;
    @(posedge clk_sys_i);
    #1;
  endtask : exec

  task automatic scen_clear(input logic assigned);
    @(posedge clk_sys_i);
    prescale_to_wdt_i <= assigned;
    exec(exec_pkg::CLR_WDT_WORD, 1'b1);
    check(watchdog_counter_o, exec_pkg::WDT_ZERO);
    check(prescaler_o, assigned ? exec_pkg::PRESCALE_ZERO : p + 8'h01);
    check({7'h00, timeout_status_bit_o}, 8'h01);
    check({7'h00, powerdown_status_bit_o}, 8'h01);
    check({7'h00, zero_flag_o}, {7'h00, z});
    check({7'h00, file_we_o}, 8'h00);
  endtask : scen_clear

  // Invalid slot must leave the free-running prescaler alone
  task automatic scen_ignored;
    exec(exec_pkg::CLR_WDT_WORD, 1'b0);
    check(prescaler_o, p + 8'h01);
    check(watchdog_counter_o, wd + 8'h01);
  endtask : scen_ignored

  // start is what file f holds on entry
  task automatic scen_comp_dec(input logic [4:0] f, input logic [7:0] start);
    a = ~start;
    exec(exec_pkg::COMP_OP | 12'h020 | {7'h00, f}, 1'b1);
    check({7'h00, file_we_o}, 8'h01);
    check({3'h0, file_addr_o}, {3'h0, f});
    check(file_data_o, a);
    check({7'h00, zero_flag_o}, {7'h00, a == 8'h00});
    exec(exec_pkg::DEC_OP | 12'h020 | {7'h00, f}, 1'b1);
    check(file_data_o, a - 8'h01);
    check({3'h0, file_addr_o}, {3'h0, f});
    check({7'h00, zero_flag_o}, {7'h00, a == 8'h01});
    exec(exec_pkg::COMP_OP | {7'h00, f}, 1'b1);
    check(wreg_o, ~(a - 8'h01));
    check({7'h00, file_we_o}, 8'h00);
    check({7'h00, zero_flag_o}, {7'h00, a == 8'h00});
    exec(exec_pkg::DEC_OP | {7'h00, f}, 1'b1);
    check(wreg_o, a - 8'h02);
    check({7'h00, file_we_o}, 8'h00);
    check({7'h00, zero_flag_o}, {7'h00, a == 8'h02});
  endtask : scen_comp_dec

  // Four words on file 0x0a in consecutive slots, then a clear; each after the first reads the previous write
  task automatic scen_back2back;
    @(posedge clk_sys_i);
    fetch_word_i  <= exec_pkg::DEC_OP | 12'h02a;
    fetch_valid_i <= 1'b1;
    @(posedge clk_sys_i);
    fetch_word_i  <= exec_pkg::COMP_OP | 12'h02a;
    @(posedge clk_sys_i);
    fetch_word_i  <= exec_pkg::DEC_OP | 12'h02a;
    #1;
    check(file_data_o, 8'hff);
    check({7'h00, file_we_o}, 8'h01);
    @(posedge clk_sys_i);
    fetch_word_i  <= exec_pkg::COMP_OP | 12'h02a;
    #1;
    check(file_data_o, 8'h00);
    check({7'h00, zero_flag_o}, 8'h01);
    @(posedge clk_sys_i);
    fetch_word_i  <= exec_pkg::CLR_WDT_WORD;
    #1;
    check(file_data_o, 8'hff);
    check({7'h00, zero_flag_o}, 8'h00);
    @(posedge clk_sys_i);
    fetch_valid_i <= 1'b0;
    #1;
    check(file_data_o, 8'h00);
    check({7'h00, zero_flag_o}, 8'h01);
    @(posedge clk_sys_i);
    #1;
    check(watchdog_counter_o, exec_pkg::WDT_ZERO);
    check({7'h00, zero_flag_o}, 8'h01);
    check({7'h00, file_we_o}, 8'h00);
  endtask : scen_back2back

  initial begin
    repeat (5) @(posedge clk_sys_i);
    #1;
    check(wreg_o, exec_pkg::WREG_RESET);
    check({7'h00, timeout_status_bit_o}, 8'h01);
    check({7'h00, powerdown_status_bit_o}, 8'h01);
    repeat (5) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    scen_clear(1'b1);
    scen_clear(1'b0);
    scen_ignored();
    scen_comp_dec(5'h00, 8'h00);
    scen_comp_dec(5'h1f, 8'h00);
    scen_comp_dec(5'h05, 8'h00);
    scen_comp_dec(5'h05, 8'hfe);
    scen_back2back();
    close_out();
  end
endmodule : wdt_clear_comp_dec_exec_tb_top
`default_nettype wire
